// File: shared/ahs_pkg.sv
// Shared constants and types for both ends of the codec serial framing link.
package ahs_pkg;
    localparam int WORD_BITS = 16;
    localparam int FRAME_SCLKS = 64;
    localparam logic [4:0] CNT_LOAD = 5'h10;
    localparam logic [15:0] CTRL_RESET = 16'h0300;
    localparam logic [2:0] MDIV_RESET = 3'h4;
    localparam int TEST_B = 15;
    localparam int TEST_A = 14;
    localparam int MDIV_C = 13;
    localparam int MDIV_B = 12;
    localparam int MDIV_A = 8;
    localparam int CFG_GEN_FS = 0;
    localparam int CFG_FMT_LO = 1;
    localparam int CFG_FMT_HI = 2;
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_TX_DATA = 8'h04;
    localparam logic [7:0] REG_TX_CTRL = 8'h08;
    localparam logic [7:0] REG_RX_DATA = 8'h0C;
    localparam logic [7:0] REG_RX_CTRL = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {AHS_IDLE, AHS_DATA, AHS_CTRL} ahs_phase_t;
endpackage

// File: shared/ahs_link_if.sv
// Serial link between the codec end and the host end.
`timescale 1ns/10ps
`default_nettype none
interface ahs_link_if (
    input wire logic sclk,
    input wire logic link_rst_n
);
    logic fs_dev_o;
    logic fs_dev_oe;
    logic fs_host_o;
    logic fs_host_oe;
    logic fs;
    logic dout;
    logic din;

    // The frame sync line idles high when neither end drives it.
    assign fs = fs_dev_oe ? fs_dev_o : (fs_host_oe ? fs_host_o : 1'b1);

    modport dev (
        input sclk,
        input link_rst_n,
        input fs,
        input din,
        output fs_dev_o,
        output fs_dev_oe,
        output dout
    );
    modport host (
        input sclk,
        input fs,
        input dout,
        output fs_host_o,
        output fs_host_oe,
        output din
    );
endinterface
`default_nettype wire

// File: verilog/ahs_dev.sv
// Codec end of the serial framing link, clocked by the shift clock.
`timescale 1ns/10ps
`default_nettype none
module ahs_dev #(
    parameter int FRAME_LEN = ahs_pkg::FRAME_SCLKS
) (
    ahs_link_if.dev lnk,
    input wire logic ms_master,
    input wire logic hw_format_sel_lo,
    input wire logic hw_format_sel_hi,
    input wire logic [15:0] adc_word,
    output logic [15:0] dac_word_q,
    output logic dac_strobe_q,
    output logic [15:0] ctrl_q,
    output logic ctrl_strobe_q,
    output logic [2:0] m_div_q,
    output logic control_mode_q,
    output logic [15:0] period_q
);
    localparam logic [15:0] F_LAST = 16'(FRAME_LEN - 1);
    localparam logic [15:0] F_MID = 16'(FRAME_LEN / 2 - 1);

    // Returns the M divider for a code, or zero for a reserved code.
    function automatic logic [2:0] ahs_mdiv(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        unique case (code)
            3'h0: m = 3'h3;
            3'h1: m = 3'h4;
            3'h6: m = 3'h1;
            3'h7: m = 3'h2;
            default: m = 3'h0;
        endcase
        return m;
    endfunction

    ahs_pkg::ahs_phase_t phase_q;
    logic fs_prev_q;
    logic [4:0] cnt_q;
    logic [15:0] sreg_q;
    logic [15:0] rx_q;
    logic ctl_pend_q;
    logic [15:0] per_cnt_q;
    logic [15:0] fcnt_q;
    logic dout_q;
    logic [18:0] pin_meta_q;
    logic [18:0] pin_sync_q;

    wire logic clk;
    wire logic rst_n;
    wire logic fs_fall;
    wire logic busy;
    wire logic last_bit;
    wire logic [15:0] rx_word;
    wire logic sw_mode;
    wire logic ctl_req;
    wire logic [15:0] load_word;
    wire logic [2:0] m_code;
    wire logic [2:0] m_new;
    wire logic gen_primary;
    wire logic gen_secondary;
    wire logic ms_master_s;
    wire logic fmt_lo_s;
    wire logic fmt_hi_s;
    wire logic [15:0] adc_word_s;

    assign clk = lnk.sclk;
    assign rst_n = lnk.link_rst_n;
    assign ms_master_s = pin_sync_q[18];
    assign fmt_lo_s = pin_sync_q[17];
    assign fmt_hi_s = pin_sync_q[16];
    assign adc_word_s = pin_sync_q[15:0];
    assign fs_fall = fs_prev_q & ~lnk.fs;
    assign busy = (phase_q != ahs_pkg::AHS_IDLE);
    assign last_bit = busy && (cnt_q == 5'h01);
    assign rx_word = {rx_q[14:0], lnk.din};
    assign sw_mode = ~fmt_hi_s & ~fmt_lo_s;
    assign ctl_req = fmt_hi_s | (sw_mode & rx_word[0]);
    assign load_word = ctl_pend_q ? ctrl_q : adc_word_s;
    assign m_code = {rx_word[ahs_pkg::MDIV_C], rx_word[ahs_pkg::MDIV_B],
                     rx_word[ahs_pkg::MDIV_A]};
    assign m_new = ahs_mdiv(m_code);
    assign gen_primary = ms_master_s && (fcnt_q == F_LAST);
    assign gen_secondary = ms_master_s && (fcnt_q == F_MID) && ctl_pend_q;
    assign lnk.dout = dout_q;

    // Role pin, format pins and sample word come from outside the shift clock domain.
    always_ff @(posedge clk) begin
        pin_meta_q <= {ms_master, hw_format_sel_lo, hw_format_sel_hi, adc_word};
        pin_sync_q <= pin_meta_q;
    end

    // Shift engine: a falling edge loads a word, then sixteen bits move each way.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fs_prev_q <= 1'b1;
            phase_q <= ahs_pkg::AHS_IDLE;
            cnt_q <= 5'h00;
            sreg_q <= 16'h0000;
            rx_q <= 16'h0000;
            dout_q <= 1'b0;
        end else begin
            fs_prev_q <= lnk.fs;
            if (fs_fall) begin
                phase_q <= ctl_pend_q ? ahs_pkg::AHS_CTRL : ahs_pkg::AHS_DATA;
                cnt_q <= ahs_pkg::CNT_LOAD;
                dout_q <= load_word[15];
                sreg_q <= {load_word[14:0], 1'b0};
            end else if (busy) begin
                cnt_q <= cnt_q - 5'h01;
                rx_q <= rx_word;
                dout_q <= sreg_q[15];
                sreg_q <= {sreg_q[14:0], 1'b0};
                if (last_bit) begin
                    phase_q <= ahs_pkg::AHS_IDLE;
                end
            end
        end
    end

    // Completed data word goes to the converter side and decides the next interval.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dac_word_q <= 16'h0000;
            dac_strobe_q <= 1'b0;
            control_mode_q <= 1'b0;
        end else begin
            dac_strobe_q <= last_bit && (phase_q == ahs_pkg::AHS_DATA);
            if (last_bit && (phase_q == ahs_pkg::AHS_DATA)) begin
                dac_word_q <= sw_mode ? {rx_word[15:1], 1'b0} : rx_word;
                control_mode_q <= ctl_req;
            end
        end
    end

    // Pending control interval is armed by a data word and used by the next edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_pend_q <= 1'b0;
        end else if (fs_fall && ctl_pend_q) begin
            ctl_pend_q <= 1'b0;
        end else if (last_bit && (phase_q == ahs_pkg::AHS_DATA)) begin
            ctl_pend_q <= ctl_req;
        end
    end

    // Control register is written only by a completed control interval.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= ahs_pkg::CTRL_RESET;
            ctrl_strobe_q <= 1'b0;
            m_div_q <= ahs_pkg::MDIV_RESET;
        end else begin
            ctrl_strobe_q <= last_bit && (phase_q == ahs_pkg::AHS_CTRL);
            if (last_bit && (phase_q == ahs_pkg::AHS_CTRL)) begin
                ctrl_q <= rx_word;
                if (m_new != 3'h0) begin
                    m_div_q <= m_new;
                end
            end
        end
    end

    // Sampling period counts shift clocks between primary edges only.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            per_cnt_q <= 16'h0000;
            period_q <= 16'h0000;
        end else if (fs_fall && !ctl_pend_q) begin
            per_cnt_q <= 16'h0001;
            period_q <= per_cnt_q;
        end else begin
            per_cnt_q <= per_cnt_q + 16'h0001;
        end
    end

    // As master the codec drives frame sync low for one clock per edge it makes.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fcnt_q <= 16'h0000;
            lnk.fs_dev_o <= 1'b1;
            lnk.fs_dev_oe <= 1'b0;
        end else begin
            lnk.fs_dev_oe <= ms_master_s;
            lnk.fs_dev_o <= ~(gen_primary | gen_secondary);
            if (!ms_master_s || (fcnt_q == F_LAST)) begin
                fcnt_q <= 16'h0000;
            end else begin
                fcnt_q <= fcnt_q + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// File: verilog/ahs_host.sv
// Host end of the serial framing link with an AXI4-Lite register port.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ahs_host #(
    parameter int FRAME_LEN = ahs_pkg::FRAME_SCLKS
) (
    ahs_link_if.host lnk,
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    localparam logic [15:0] F_LAST = 16'(FRAME_LEN - 1);
    localparam logic [15:0] F_MID = 16'(FRAME_LEN / 2 - 1);

    // Merges written byte lanes into a register value.
    function automatic logic [31:0] ahs_wmerge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [7:0] aw_q;
    logic aw_have_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic w_have_q;
    logic [2:0] cfg_q;
    logic [15:0] txd_q;
    logic [15:0] txc_q;
    logic [15:0] rxd_q;
    logic [15:0] rxc_q;
    logic [7:0] rx_cnt_q;
    logic dirty_q;
    logic a_req_q;
    logic [1:0] a_ack_s;
    logic [34:0] a_bund_q;
    logic [2:0] a_rq_s;
    logic a_ak_q;
    logic [1:0] l_rst_s;
    logic [2:0] l_req_s;
    logic l_ack_q;
    logic [34:0] l_bund_q;
    logic [31:0] l_live_q;
    logic l_new_q;
    logic l_rq_q;
    logic [1:0] l_ak_s;
    logic [31:0] l_hold_q;
    ahs_pkg::ahs_phase_t phase_q;
    logic fs_prev_q;
    logic [4:0] cnt_q;
    logic [15:0] sreg_q;
    logic [15:0] rx_q;
    logic [15:0] tx_sent_q;
    logic ctl_pend_q;
    logic [15:0] fcnt_q;

    wire logic do_write = aw_have_q && w_have_q && !bvalid;
    wire logic wr_map = (aw_q == ahs_pkg::REG_CONFIG) || (aw_q == ahs_pkg::REG_TX_DATA)
                        || (aw_q == ahs_pkg::REG_TX_CTRL);
    wire logic [31:0] wm_cfg = ahs_wmerge({29'h0, cfg_q}, w_q, ws_q);
    wire logic [31:0] wm_txd = ahs_wmerge({16'h0, txd_q}, w_q, ws_q);
    wire logic [31:0] wm_txc = ahs_wmerge({16'h0, txc_q}, w_q, ws_q);
    wire logic launch = dirty_q && (a_req_q == a_ack_s[1]);
    wire logic rd_map = (araddr <= ahs_pkg::REG_STATUS) && (araddr[1:0] == 2'h0);
    wire logic [31:0] rd_val =
        (araddr == ahs_pkg::REG_CONFIG) ? {29'h0, cfg_q} :
        (araddr == ahs_pkg::REG_TX_DATA) ? {16'h0, txd_q} :
        (araddr == ahs_pkg::REG_TX_CTRL) ? {16'h0, txc_q} :
        (araddr == ahs_pkg::REG_RX_DATA) ? {16'h0, rxd_q} :
        (araddr == ahs_pkg::REG_RX_CTRL) ? {16'h0, rxc_q} :
        (araddr == ahs_pkg::REG_STATUS) ? {23'h0, rx_cnt_q, dirty_q} : 32'h0;
    wire logic l_rst_n = l_rst_s[1];
    wire logic fs_fall = fs_prev_q & ~lnk.fs;
    wire logic busy = (phase_q != ahs_pkg::AHS_IDLE);
    wire logic last_bit = busy && (cnt_q == 5'h01);
    wire logic [15:0] rx_word = {rx_q[14:0], lnk.dout};
    wire logic gen_fs = l_bund_q[32 + ahs_pkg::CFG_GEN_FS];
    wire logic fmt_lo = l_bund_q[32 + ahs_pkg::CFG_FMT_LO];
    wire logic fmt_hi = l_bund_q[32 + ahs_pkg::CFG_FMT_HI];
    wire logic ctl_req = fmt_hi | (~fmt_hi & ~fmt_lo & tx_sent_q[0]);
    wire logic [15:0] ctl_word = {2'h0, l_bund_q[13:0]};
    wire logic [15:0] load_word = ctl_pend_q ? ctl_word : l_bund_q[31:16];
    wire logic l_launch = l_new_q && (l_rq_q == l_ak_s[1]);

    // Write channel: address and data are taken in either order, then answered.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0;
            ws_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= ahs_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_q <= wdata;
                ws_q <= wstrb;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_map ? ahs_pkg::RESP_OKAY : ahs_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    assign awready = !aw_have_q && !bvalid;
    assign wready = !w_have_q && !bvalid;

    // Register file and the launch of settings toward the link domain.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= 3'h0;
            txd_q <= 16'h0000;
            txc_q <= 16'h0000;
            dirty_q <= 1'b0;
            a_req_q <= 1'b0;
            a_bund_q <= 35'h0;
            a_ack_s <= 2'h0;
        end else begin
            a_ack_s <= {a_ack_s[0], l_ack_q};
            if (do_write && (aw_q == ahs_pkg::REG_CONFIG)) cfg_q <= wm_cfg[2:0];
            if (do_write && (aw_q == ahs_pkg::REG_TX_DATA)) txd_q <= wm_txd[15:0];
            if (do_write && (aw_q == ahs_pkg::REG_TX_CTRL)) txc_q <= wm_txc[15:0];
            dirty_q <= (do_write && wr_map) || (dirty_q && !launch);
            if (launch) begin
                a_bund_q <= {cfg_q, txd_q, txc_q};
                a_req_q <= ~a_req_q;
            end
        end
    end

    // Read channel and capture of words arriving from the link domain.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= ahs_pkg::RESP_OKAY;
            rxd_q <= 16'h0000;
            rxc_q <= 16'h0000;
            rx_cnt_q <= 8'h00;
            a_rq_s <= 3'h0;
            a_ak_q <= 1'b0;
        end else begin
            arready <= !rvalid && !arready && arvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= rd_val;
                rresp <= rd_map ? ahs_pkg::RESP_OKAY : ahs_pkg::RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
            a_rq_s <= {a_rq_s[1:0], l_rq_q};
            if (a_rq_s[1] != a_rq_s[2]) begin
                rxd_q <= l_hold_q[31:16];
                rxc_q <= l_hold_q[15:0];
                rx_cnt_q <= rx_cnt_q + 8'h01;
                a_ak_q <= a_rq_s[1];
            end
        end
    end

    // Link domain reset and the crossings into and out of it.
    always_ff @(posedge lnk.sclk) begin
        l_rst_s <= {l_rst_s[0], aresetn};
        if (!l_rst_n) begin
            l_req_s <= 3'h0;
            l_ack_q <= 1'b0;
            l_bund_q <= 35'h0;
            l_ak_s <= 2'h0;
            l_rq_q <= 1'b0;
            l_hold_q <= 32'h0;
            l_new_q <= 1'b0;
            l_live_q <= 32'h0;
        end else begin
            l_req_s <= {l_req_s[1:0], a_req_q};
            if (l_req_s[1] != l_req_s[2]) begin
                l_bund_q <= a_bund_q;
                l_ack_q <= l_req_s[1];
            end
            l_ak_s <= {l_ak_s[0], a_ak_q};
            if (last_bit && (phase_q == ahs_pkg::AHS_DATA)) l_live_q[31:16] <= rx_word;
            if (last_bit && (phase_q == ahs_pkg::AHS_CTRL)) l_live_q[15:0] <= rx_word;
            l_new_q <= last_bit || (l_new_q && !l_launch);
            if (l_launch) begin
                l_hold_q <= l_live_q;
                l_rq_q <= ~l_rq_q;
            end
        end
    end

    // Link shift engine, the mirror of the codec end.
    always_ff @(posedge lnk.sclk) begin
        if (!l_rst_n) begin
            fs_prev_q <= 1'b1;
            phase_q <= ahs_pkg::AHS_IDLE;
            cnt_q <= 5'h00;
            sreg_q <= 16'h0000;
            rx_q <= 16'h0000;
            tx_sent_q <= 16'h0000;
            ctl_pend_q <= 1'b0;
            lnk.din <= 1'b0;
        end else begin
            fs_prev_q <= lnk.fs;
            if (fs_fall) begin
                phase_q <= ctl_pend_q ? ahs_pkg::AHS_CTRL : ahs_pkg::AHS_DATA;
                cnt_q <= ahs_pkg::CNT_LOAD;
                lnk.din <= load_word[15];
                sreg_q <= {load_word[14:0], 1'b0};
                if (!ctl_pend_q) tx_sent_q <= load_word;
                if (ctl_pend_q) ctl_pend_q <= 1'b0;
            end else if (busy) begin
                cnt_q <= cnt_q - 5'h01;
                rx_q <= rx_word;
                lnk.din <= sreg_q[15];
                sreg_q <= {sreg_q[14:0], 1'b0};
                if (last_bit) phase_q <= ahs_pkg::AHS_IDLE;
                if (last_bit && (phase_q == ahs_pkg::AHS_DATA)) ctl_pend_q <= ctl_req;
            end
        end
    end

    // When the CFG_GEN_FS bit is set the host makes both frame sync edges.
    always_ff @(posedge lnk.sclk) begin
        if (!l_rst_n) begin
            fcnt_q <= 16'h0000;
            lnk.fs_host_o <= 1'b1;
            lnk.fs_host_oe <= 1'b0;
        end else begin
            lnk.fs_host_oe <= gen_fs;
            lnk.fs_host_o <= ~(gen_fs && ((fcnt_q == F_LAST) ||
                                ((fcnt_q == F_MID) && ctl_pend_q)));
            fcnt_q <= (!gen_fs || (fcnt_q == F_LAST)) ? 16'h0000 : fcnt_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: verif/ahs_assertions.sv
// Wire-level checker for the codec serial framing link.
`timescale 1ns/10ps
`default_nettype none
module ahs_checker #(
    parameter int FRAME_LEN = 64
) (
    input wire logic sclk,
    input wire logic link_rst_n,
    input wire logic fs,
    input wire logic fs_dev_oe,
    input wire logic fs_host_oe,
    input wire logic din
);
    localparam int HALF = FRAME_LEN / 2;
    logic fs_prev_q;
    logic seen_q;
    logic last_ctrl_q;
    logic [15:0] gap_q;
    wire logic fell_w = fs_prev_q & ~fs;
    wire logic ctrl_w = fell_w & seen_q & (gap_q == 16'(HALF)) & ~last_ctrl_q;

    default clocking cb @(posedge sclk);
    endclocking
    default disable iff (!link_rst_n);

    always_ff @(posedge sclk) begin
        if (!link_rst_n) begin
            fs_prev_q <= 1'b1;
            seen_q <= 1'b0;
            last_ctrl_q <= 1'b0;
            gap_q <= 16'h0000;
        end else begin
            fs_prev_q <= fs;
            if (fell_w) begin
                seen_q <= 1'b1;
                last_ctrl_q <= ctrl_w;
                gap_q <= 16'h0001;
            end else if (gap_q != 16'hFFFF) begin
                gap_q <= gap_q + 16'h0001;
            end
        end
    end

    chk_single_driver: assert property (!(fs_dev_oe && fs_host_oe))
        else $error("both ends drive frame sync");
    chk_sync_short: assert property ($fell(fs) |=> fs)
        else $error("frame sync low longer than one clock");
    chk_idle_high: assert property (!fs_dev_oe && !fs_host_oe |-> fs)
        else $error("undriven frame sync not high");
    chk_gap_legal: assert property (fell_w && seen_q |->
        (gap_q == 16'(FRAME_LEN)) || (gap_q == 16'(HALF)))
        else $error("frame sync spacing wrong");
    chk_interval_whole: assert property ($fell(fs) |=>
        (!$fell(fs)) [*8] ##1 (!$fell(fs)) [*8])
        else $error("interval cut short");
    chk_ctrl_midway: assert property (ctrl_w |-> ##HALF fell_w)
        else $error("secondary sync shifted the frame period");
    chk_test_bits: assert property (ctrl_w |=> !din ##1 !din)
        else $error("test bits sent nonzero");
    chk_frame_bound: assert property (seen_q |-> gap_q <= 16'(FRAME_LEN))
        else $error("primary frame sync overdue");

    cover property (ctrl_w);
    cover property (fell_w && seen_q && !ctrl_w);
    cover property (fell_w && gap_q == 16'(FRAME_LEN));
endmodule
`default_nettype wire

// File: verif/ahs_bench.sv
// Self-checking bench joining both ends of the codec serial framing link.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module ahs_bench;
    localparam int FL = 40;
    localparam logic [2:0] CODES [5] = '{3'h0, 3'h1, 3'h6, 3'h7, 3'h2};
    logic aclk, aresetn, sclk, link_rst_n, ms_master, hw_format_sel_lo, hw_format_sel_hi;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [15:0] adc_word, dac_word_q, ctrl_q, period_q;
    logic dac_strobe_q, ctrl_strobe_q, control_mode_q;
    logic [2:0] m_div_q;
    int n_mismatch, tests_run, seed;

    ahs_link_if lnk (.sclk(sclk), .link_rst_n(link_rst_n));
    ahs_dev #(.FRAME_LEN(FL)) ahs_dev_inst (.lnk, .ms_master, .hw_format_sel_lo,
        .hw_format_sel_hi, .adc_word, .dac_word_q, .dac_strobe_q, .ctrl_q, .ctrl_strobe_q,
        .m_div_q, .control_mode_q, .period_q);
    ahs_host #(.FRAME_LEN(FL)) ahs_host_inst (.lnk, .aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    ahs_checker #(.FRAME_LEN(FL)) ahs_checker_inst (.sclk(sclk), .link_rst_n(link_rst_n),
        .fs(lnk.fs), .fs_dev_oe(lnk.fs_dev_oe), .fs_host_oe(lnk.fs_host_oe), .din(lnk.din));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        sclk = 1'b0;
        #1.7;
        forever #3 sclk = ~sclk;
    end

    function automatic logic [2:0] m_model(input logic [2:0] c, input logic [2:0] prev);
        case (c)
            3'h0: return 3'h3;
            3'h1: return 3'h4;
            3'h6: return 3'h1;
            3'h7: return 3'h2;
            default: return prev;
        endcase
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic guard(input int n);
        if (n > 3000) begin
            n_mismatch++;
            $display("wrong value wait expected done seen timeout");
            summarize();
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            guard(n);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            guard(n);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic frames(input int k, output int nc);
        int n;
        nc = 0;
        n = 0;
        while (k > 0) begin
            @(negedge sclk);
            n++;
            guard(n);
            if (ctrl_strobe_q) nc++;
            if (dac_strobe_q) k--;
        end
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] v, w, ev;
        logic [2:0] me;
        int nc;
        seed = 32'h64F5;
        n_mismatch = 0;
        tests_run = 0;
        {aresetn, link_rst_n, hw_format_sel_lo, hw_format_sel_hi} = 4'h0;
        ms_master = 1'b1;
        {awaddr, araddr, wdata, adc_word} = 64'h0;
        wstrb = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        link_rst_n <= 1'b1;
        `CHK("ctrl_q", ahs_pkg::CTRL_RESET, ctrl_q)
        `CHK("m_div_q", ahs_pkg::MDIV_RESET, m_div_q)
        `CHK("control_mode_q", 1'b0, control_mode_q)
        axi_wr(8'h40, 32'h0000FFFF, r);
        `CHK("bresp", ahs_pkg::RESP_SLVERR, r)
        axi_rd(8'h40, d, r);
        `CHK("rresp", ahs_pkg::RESP_SLVERR, r)
        `CHK("rdata", 32'h0, d)
        me = ahs_pkg::MDIV_RESET;
        for (int i = 0; i < 5; i++) begin
            v = 16'($random(seed));
            {v[13], v[12], v[8]} = CODES[i];
            axi_wr(ahs_pkg::REG_TX_CTRL, {16'h0, v}, r);
            axi_wr(ahs_pkg::REG_TX_DATA, 32'h1, r);
            frames(5, nc);
            me = m_model(CODES[i], me);
            ev = {2'b00, v[13:0]};
            `CHK("ctrl_q", ev, ctrl_q)
            `CHK("test_bits", 2'b00, ctrl_q[15:14])
            `CHK("m_div_q", me, m_div_q)
            `CHK("control_mode_q", 1'b1, control_mode_q)
            axi_rd(ahs_pkg::REG_RX_CTRL, d, r);
            `CHK("rx_ctrl", ev, d[15:0])
        end
        for (int m = 0; m < 3; m++) begin
            // In the last mode the host takes over frame sync across a link reset.
            @(posedge aclk);
            ms_master <= (m != 2);
            link_rst_n <= (m != 2);
            hw_format_sel_lo <= (m == 1);
            hw_format_sel_hi <= (m == 2);
            adc_word <= 16'($random(seed));
            axi_wr(ahs_pkg::REG_CONFIG, 32'((m << 1) | (m == 2)), r);
            link_rst_n <= 1'b1;
            w = 16'($random(seed));
            if (m == 0) w[0] = 1'b0;
            axi_wr(ahs_pkg::REG_TX_DATA, {16'h0, w}, r);
            frames(5, nc);
            frames(3, nc);
            `CHK("dac_word_q", w, dac_word_q)
            `CHK("period_q", 16'(FL), period_q)
            `CHK("control_mode_q", (m == 2), control_mode_q)
            `CHK("ctrl_frames", (m == 2), (nc != 0))
            axi_rd(ahs_pkg::REG_RX_DATA, d, r);
            `CHK("rx_data", adc_word, d[15:0])
        end
        summarize();
    end
endmodule
`default_nettype wire
